// ==== hdl/tbt_map.svh ====
/*
 Register offsets, field positions, reset values and timing counts of the
 10 Mbit/s twisted-pair port. Assumes a 50 MHz register/port clock.
*/
`ifndef TBT_MAP_SVH
`define TBT_MAP_SVH

`define TBT_CLK_MHZ 50

// Register indices and byte addresses
`define TBT_ADDR_MODE 8'h00
`define TBT_ADDR_STAT 8'h04
`define TBT_IDX_POLSTAT 28
`define TBT_IDX_SQCTRL 30
`define TBT_ADDR_POLSTAT (`TBT_IDX_POLSTAT * 4)
`define TBT_ADDR_SQCTRL (`TBT_IDX_SQCTRL * 4)

// Field positions
`define TBT_MODE_FDX 0
`define TBT_MODE_RPT 1
`define TBT_STAT_LINK 0
`define TBT_STAT_CRS 1
`define TBT_STAT_COL 2
`define TBT_STAT_JAB 3
`define TBT_POL_INV 6
`define TBT_SQ_EXT 4
`define TBT_SQ_APD_DIS 3

// Reset values
`define TBT_MODE_RST 2'h0
`define TBT_SQCTRL_RST 1'b0

// Times as printed, and cycle counts derived from them
`define TBT_T_OPP_NS 150
`define TBT_OPP_CYC ((`TBT_T_OPP_NS * `TBT_CLK_MHZ) / 1000)
`define TBT_T_QUIET_NS 200
`define TBT_QUIET_CYC ((`TBT_T_QUIET_NS * `TBT_CLK_MHZ) / 1000)
`define TBT_T_EOF_NS 150
`define TBT_EOF_CYC ((`TBT_T_EOF_NS * `TBT_CLK_MHZ) / 1000)
`define TBT_T_MID_NS 75
`define TBT_MID_CYC ((`TBT_T_MID_NS * `TBT_CLK_MHZ + 999) / 1000)
`define TBT_T_BIT_NS 100
`define TBT_BIT_CYC ((`TBT_T_BIT_NS * `TBT_CLK_MHZ) / 1000)
`define TBT_T_LPW_NS 100
`define TBT_LPW_CYC ((`TBT_T_LPW_NS * `TBT_CLK_MHZ) / 1000)
`define TBT_LP_PERIOD_US 16000
`define TBT_LINK_LOSS_US 100000
`define TBT_JABBER_US 20000

// Polarity decision counts
`define TBT_LP_INV_N 7
`define TBT_PKT_INV_N 3

`endif

// ==== hdl/tbt_pkg.sv ====
/*
 Types of the 10 Mbit/s twisted-pair port: state enumerations, line and
 MAC-side carriers, and the packed state record of the port.
 Assumes the constants of tbt_map.svh.
*/
package tbt_pkg;

   typedef enum logic [1:0] {SQ_IDLE, SQ_OPP, SQ_ORIG, SQ_VALID} tbt_sq_t;
   typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_ETD} tbt_tx_t;

   typedef struct packed {
      logic pos;
      logic neg;
   } tbt_rx_line_t;

   typedef struct packed {
      logic level;
      logic drive;
   } tbt_tx_line_t;

   typedef struct packed {
      logic crs;
      logic rx_dv;
      logic rx_bit;
      logic rx_bit_vld;
      logic col;
   } tbt_mac_rx_t;

   typedef struct packed {
      logic pos_m;
      logic pos_s;
      logic neg_m;
      logic neg_s;
      tbt_sq_t sq_st;
      logic [3:0] sq_cnt;
      logic first_neg;
      logic last_neg;
      logic lvl;
      logic [3:0] mid_cnt;
      logic dec_seen;
      logic pol_inv;
      logic [2:0] lp_inv_cnt;
      logic [1:0] pk_inv_cnt;
      logic link_ok;
      logic [31:0] loss_cnt;
      tbt_tx_t tx_st;
      logic [2:0] div;
      logic tx_bit;
      logic tx_take;
      logic [31:0] jab_cnt;
      logic jabber;
      logic [31:0] lp_cnt;
      logic [2:0] lp_w;
      tbt_tx_line_t tx;
      tbt_mac_rx_t mac;
      logic sq_reduced;
      logic [1:0] mode;
      logic ext_sq;
      logic apd_dis;
      logic [31:0] prdata;
      logic pslverr;
   } tbt_state_t;

endpackage

// ==== hdl/tbt_port.sv ====
/*
 One 10 Mbit/s twisted-pair port: Manchester transmit with end-of-frame
 delimiter, smart squelch, receive decoding, carrier sense and collision,
 link pulses and link loss, automatic polarity correction, APB registers.
 Assumes squelch comparator outputs from the analog receiver on the line
 side and MAC transmit signals from logic on pclk.
*/
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/10ps
`include "tbt_map.svh"

module tbt_port #(
   parameter int unsigned LP_PERIOD_CYC = `TBT_LP_PERIOD_US * `TBT_CLK_MHZ,
   parameter int unsigned LINK_LOSS_CYC = `TBT_LINK_LOSS_US * `TBT_CLK_MHZ,
   parameter int unsigned JABBER_CYC = `TBT_JABBER_US * `TBT_CLK_MHZ
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire tbt_pkg::tbt_rx_line_t twisted_pair_rx_input,
   output tbt_pkg::tbt_tx_line_t tx_line,
   output logic sq_reduced,
   output logic sq_extended,
   input wire logic tx_en,
   input wire logic tx_data,
   output logic tx_take,
   output tbt_pkg::tbt_mac_rx_t mac_rx,
   output logic link_ok,
   output logic pol_inverted
);

   generate
      if (LP_PERIOD_CYC < 2 || LINK_LOSS_CYC < 2 || JABBER_CYC < 2) begin
         $error("tbt_port: counts must be at least 2");
      end
   endgenerate

   tbt_pkg::tbt_state_t st_ff;
   tbt_pkg::tbt_state_t nxt_st;

   always_comb begin
      logic p;
      logic q;
      logic inv;
      logic lp_norm;
      logic lp_inv;
      logic eop;
      logic pkt_start;
      logic rx_car;
      logic cell_start;
      logic tx_go;
      logic tx_act;
      logic fdx;
      logic rpt;
      p = 1'b0;
      q = 1'b0;
      inv = 1'b0;
      lp_norm = 1'b0;
      lp_inv = 1'b0;
      eop = 1'b0;
      pkt_start = 1'b0;
      rx_car = 1'b0;
      cell_start = 1'b0;
      tx_go = 1'b0;
      tx_act = 1'b0;
      fdx = st_ff.mode[`TBT_MODE_FDX];
      rpt = st_ff.mode[`TBT_MODE_RPT];
      nxt_st = st_ff;

      // Comparator levels into pclk
      nxt_st.pos_m = twisted_pair_rx_input.pos;
      nxt_st.pos_s = st_ff.pos_m;
      nxt_st.neg_m = twisted_pair_rx_input.neg;
      nxt_st.neg_s = st_ff.neg_m;

      // Polarity-corrected crossings
      inv = st_ff.pol_inv & ~st_ff.apd_dis;
      p = inv ? st_ff.neg_s : st_ff.pos_s;
      q = inv ? st_ff.pos_s : st_ff.neg_s;
      if (p & ~q) begin
         nxt_st.last_neg = 1'b0;
      end else if (q & ~p) begin
         nxt_st.last_neg = 1'b1;
      end

      // Smart squelch
      nxt_st.sq_cnt = 4'(st_ff.sq_cnt + 4'h1);
      case (st_ff.sq_st)
         tbt_pkg::SQ_IDLE: begin
            nxt_st.sq_cnt = 4'h0;
            if (p | q) begin
               nxt_st.sq_st = tbt_pkg::SQ_OPP;
               nxt_st.first_neg = q & ~p;
            end
         end
         tbt_pkg::SQ_OPP: begin
            if (st_ff.first_neg ? p : q) begin
               nxt_st.sq_st = tbt_pkg::SQ_ORIG;
               nxt_st.sq_cnt = 4'h0;
            end else if (st_ff.sq_cnt == 4'(`TBT_OPP_CYC - 1)) begin
               // Lone pulse: a link pulse
               nxt_st.sq_st = tbt_pkg::SQ_IDLE;
               lp_norm = ~st_ff.first_neg;
               lp_inv = st_ff.first_neg;
            end
         end
         tbt_pkg::SQ_ORIG: begin
            if (st_ff.first_neg ? q : p) begin
               nxt_st.sq_st = tbt_pkg::SQ_VALID;
               nxt_st.sq_cnt = 4'h0;
               nxt_st.mid_cnt = 4'hF;
               nxt_st.dec_seen = 1'b0;
               nxt_st.lvl = ~st_ff.first_neg;
               pkt_start = 1'b1;
            end else if (st_ff.sq_cnt == 4'(`TBT_OPP_CYC - 1)) begin
               nxt_st.sq_st = tbt_pkg::SQ_IDLE;
            end
         end
         tbt_pkg::SQ_VALID: begin
            if (p | q) begin
               nxt_st.sq_cnt = 4'h0;
            end else if (st_ff.sq_cnt == 4'(`TBT_QUIET_CYC)) begin
               nxt_st.sq_st = tbt_pkg::SQ_IDLE;
               eop = 1'b1;
            end
         end
         default: begin
            nxt_st.sq_st = tbt_pkg::SQ_IDLE;
         end
      endcase
      // Link down: lone pulses still timed, packets refused
      if (~st_ff.link_ok && nxt_st.sq_st != tbt_pkg::SQ_OPP) begin
         nxt_st.sq_st = tbt_pkg::SQ_IDLE;
      end
      nxt_st.sq_reduced = nxt_st.sq_st == tbt_pkg::SQ_VALID;

      // Manchester decoder: mid-bit edges are at least 3/4 cell apart
      nxt_st.mac.rx_bit_vld = 1'b0;
      if (st_ff.sq_st == tbt_pkg::SQ_VALID) begin
         if (p & ~q) begin
            nxt_st.lvl = 1'b1;
         end else if (q & ~p) begin
            nxt_st.lvl = 1'b0;
         end
         if (st_ff.mid_cnt != 4'hF) begin
            nxt_st.mid_cnt = 4'(st_ff.mid_cnt + 4'h1);
         end
         if (nxt_st.lvl != st_ff.lvl &&
             st_ff.mid_cnt >= 4'(`TBT_MID_CYC)) begin
            nxt_st.mac.rx_bit = nxt_st.lvl;
            nxt_st.mac.rx_bit_vld = st_ff.link_ok;
            nxt_st.mid_cnt = 4'h0;
            nxt_st.dec_seen = 1'b1;
         end
      end
      rx_car = st_ff.sq_st == tbt_pkg::SQ_VALID &&
               !(st_ff.dec_seen && st_ff.mid_cnt >= 4'(`TBT_EOF_CYC));

      // Automatic polarity
      if (st_ff.apd_dis) begin
         nxt_st.pol_inv = 1'b0;
         nxt_st.lp_inv_cnt = 3'h0;
         nxt_st.pk_inv_cnt = 2'h0;
      end else begin
         if (lp_norm) begin
            nxt_st.lp_inv_cnt = 3'h0;
         end else if (lp_inv) begin
            if (st_ff.lp_inv_cnt == 3'(`TBT_LP_INV_N - 1)) begin
               nxt_st.pol_inv = ~st_ff.pol_inv;
               nxt_st.lp_inv_cnt = 3'h0;
               nxt_st.pk_inv_cnt = 2'h0;
            end else begin
               nxt_st.lp_inv_cnt = 3'(st_ff.lp_inv_cnt + 3'h1);
            end
         end
         if (eop) begin
            if (!st_ff.last_neg) begin
               nxt_st.pk_inv_cnt = 2'h0;
            end else if (st_ff.pk_inv_cnt == 2'(`TBT_PKT_INV_N - 1)) begin
               nxt_st.pol_inv = ~st_ff.pol_inv;
               nxt_st.pk_inv_cnt = 2'h0;
               nxt_st.lp_inv_cnt = 3'h0;
            end else begin
               nxt_st.pk_inv_cnt = 2'(st_ff.pk_inv_cnt + 2'h1);
            end
         end
      end

      // Link integrity
      if (lp_norm | lp_inv | pkt_start) begin
         nxt_st.link_ok = 1'b1;
         nxt_st.loss_cnt = 32'h0;
      end else if (st_ff.link_ok) begin
         if (st_ff.loss_cnt == 32'(LINK_LOSS_CYC - 1)) begin
            nxt_st.link_ok = 1'b0;
         end else begin
            nxt_st.loss_cnt = st_ff.loss_cnt + 32'h1;
         end
      end
      // Pulses arriving while down still bring the link up
      if (~st_ff.link_ok && st_ff.sq_st == tbt_pkg::SQ_OPP &&
          st_ff.sq_cnt == 4'(`TBT_OPP_CYC - 1)) begin
         nxt_st.link_ok = 1'b1;
         nxt_st.loss_cnt = 32'h0;
      end

      // Bit-cell divider
      cell_start = st_ff.div == 3'(`TBT_BIT_CYC - 1);
      nxt_st.div = cell_start ? 3'h0 : 3'(st_ff.div + 3'h1);

      // Transmit sequencing
      tx_go = tx_en & st_ff.link_ok & ~st_ff.jabber;
      nxt_st.tx_take = 1'b0;
      case (st_ff.tx_st)
         tbt_pkg::TX_IDLE: begin
            if (cell_start & tx_go) begin
               nxt_st.tx_st = tbt_pkg::TX_DATA;
               nxt_st.tx_bit = tx_data;
               nxt_st.tx_take = 1'b1;
            end
         end
         tbt_pkg::TX_DATA: begin
            if (cell_start) begin
               if (tx_go) begin
                  nxt_st.tx_bit = tx_data;
                  nxt_st.tx_take = 1'b1;
               end else begin
                  nxt_st.tx_st = tbt_pkg::TX_ETD;
               end
            end
         end
         tbt_pkg::TX_ETD: begin
            if (cell_start) begin
               nxt_st.tx_st = tbt_pkg::TX_IDLE;
            end
         end
         default: begin
            nxt_st.tx_st = tbt_pkg::TX_IDLE;
         end
      endcase

      // Jabber: transmission held over the limit
      if (!tx_en) begin
         nxt_st.jab_cnt = 32'h0;
         nxt_st.jabber = 1'b0;
      end else if (st_ff.tx_st == tbt_pkg::TX_DATA && !st_ff.jabber) begin
         if (st_ff.jab_cnt == 32'(JABBER_CYC - 1)) begin
            nxt_st.jabber = 1'b1;
         end else begin
            nxt_st.jab_cnt = st_ff.jab_cnt + 32'h1;
         end
      end

      // Link pulses while nothing to send
      if (st_ff.lp_w != 3'h0) begin
         nxt_st.lp_w = 3'(st_ff.lp_w - 3'h1);
      end
      if (st_ff.tx_st == tbt_pkg::TX_IDLE && !tx_en) begin
         if (st_ff.lp_cnt == 32'(LP_PERIOD_CYC - 1)) begin
            nxt_st.lp_cnt = 32'h0;
            nxt_st.lp_w = 3'(`TBT_LPW_CYC);
         end else begin
            nxt_st.lp_cnt = st_ff.lp_cnt + 32'h1;
         end
      end else begin
         nxt_st.lp_cnt = 32'h0;
      end

      // Line drive
      case (nxt_st.tx_st)
         tbt_pkg::TX_DATA: begin
            // First three cycles inverted bit, last two cycles true bit
            nxt_st.tx.level = (nxt_st.div < 3'h3) ? ~nxt_st.tx_bit :
                              nxt_st.tx_bit;
            nxt_st.tx.drive = 1'b1;
         end
         tbt_pkg::TX_ETD: begin
            // Idle high: after a 0 the edge rises on the boundary
            nxt_st.tx.level = 1'b1;
            nxt_st.tx.drive = 1'b1;
         end
         default: begin
            nxt_st.tx.level = nxt_st.lp_w != 3'h0;
            nxt_st.tx.drive = nxt_st.lp_w != 3'h0;
         end
      endcase

      // Carrier sense and collision
      tx_act = st_ff.tx_st != tbt_pkg::TX_IDLE;
      nxt_st.mac.crs = st_ff.link_ok &
         (rx_car | (~fdx & ~rpt & tx_act));
      nxt_st.mac.rx_dv = st_ff.link_ok & rx_car;
      // Driven out on mac_rx.col and read back in the status register
      nxt_st.mac.col = st_ff.link_ok & ~fdx &
         ((tx_act & rx_car) | st_ff.jabber);

      // APB: read data and error captured in the setup cycle
      if (psel & ~penable) begin
         nxt_st.pslverr = 1'b0;
         if (paddr == `TBT_ADDR_MODE) begin
            nxt_st.prdata = {30'h0, st_ff.mode};
         end else if (paddr == `TBT_ADDR_STAT) begin
            nxt_st.prdata = {28'h0, st_ff.jabber, st_ff.mac.col,
                             st_ff.mac.crs, st_ff.link_ok};
         end else if (paddr == 8'(`TBT_ADDR_POLSTAT)) begin
            nxt_st.prdata = 32'h0;
            nxt_st.prdata[`TBT_POL_INV] = st_ff.pol_inv;
         end else if (paddr == 8'(`TBT_ADDR_SQCTRL)) begin
            nxt_st.prdata = 32'h0;
            nxt_st.prdata[`TBT_SQ_EXT] = st_ff.ext_sq;
            nxt_st.prdata[`TBT_SQ_APD_DIS] = st_ff.apd_dis;
         end else begin
            nxt_st.prdata = 32'h0;
            nxt_st.pslverr = 1'b1;
         end
      end
      if (psel & penable & pwrite) begin
         if (paddr == `TBT_ADDR_MODE) begin
            nxt_st.mode = pwdata[1:0];
         end else if (paddr == 8'(`TBT_ADDR_SQCTRL)) begin
            nxt_st.ext_sq = pwdata[`TBT_SQ_EXT];
            nxt_st.apd_dis = pwdata[`TBT_SQ_APD_DIS];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
         st_ff.sq_st <= tbt_pkg::SQ_IDLE;
         st_ff.tx_st <= tbt_pkg::TX_IDLE;
         st_ff.mode <= `TBT_MODE_RST;
         st_ff.ext_sq <= `TBT_SQCTRL_RST;
         st_ff.apd_dis <= `TBT_SQCTRL_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign prdata = st_ff.prdata;
   assign pready = 1'b1;
   assign pslverr = st_ff.pslverr;
   assign tx_line = st_ff.tx;
   assign sq_reduced = st_ff.sq_reduced;
   assign sq_extended = st_ff.ext_sq;
   assign tx_take = st_ff.tx_take;
   assign mac_rx = st_ff.mac;
   assign link_ok = st_ff.link_ok;
   assign pol_inverted = st_ff.pol_inv;

endmodule

// ==== tb/tbt_mac_model.sv ====
/*
 MAC transmit side: sends nbits of pat, one bit per tx_take.
 Assumes the port's pclk and tx_take pulse.
*/
`timescale 1ns/10ps
module tbt_mac_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic [31:0] pat,
   input wire logic [7:0] nbits,
   input wire logic tx_take,
   input wire tbt_pkg::tbt_mac_rx_t mac_rx,
   output logic tx_en,
   output logic tx_data,
   output logic col_mac
);
   logic [7:0] idx_ff;
   logic [7:0] nxt_idx;
   assign nxt_idx = idx_ff + 8'h01;
   // Carrier, not the toggling data valid
   assign col_mac = tx_en & mac_rx.crs;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_en <= 1'b0;
         tx_data <= 1'b0;
         idx_ff <= 8'h00;
      end else if (!run) begin
         tx_en <= 1'b0;
         tx_data <= ~tx_data;
         idx_ff <= 8'h00;
      end else if (tx_en && tx_take) begin
         idx_ff <= nxt_idx;
         tx_data <= pat[nxt_idx[4:0]];
         tx_en <= (nxt_idx != nbits);
      end else if (!tx_en && idx_ff == 8'h00) begin
         tx_en <= 1'b1;
         tx_data <= pat[0];
      end else if (!tx_en) begin
         tx_data <= ~tx_data;
      end
   end
endmodule

// ==== tb/tbt_port_props.sv ====
/*
 Checker of the tbt_port pins: transmit cells, receive end timing,
 link-down silence.
 Assumes it is bound onto tbt_port.
*/
`timescale 1ns/10ps
module tbt_port_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire tbt_pkg::tbt_rx_line_t twisted_pair_rx_input,
   input wire tbt_pkg::tbt_tx_line_t tx_line,
   input wire logic sq_reduced,
   input wire logic tx_en,
   input wire logic tx_take,
   input wire tbt_pkg::tbt_mac_rx_t mac_rx,
   input wire logic link_ok
);
   logic [4:0] quiet_ff;
   logic [4:0] nxt_quiet;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Cycles since either comparator last fired
   always_comb begin
      nxt_quiet = quiet_ff;
      if (twisted_pair_rx_input.pos || twisted_pair_rx_input.neg) begin
         nxt_quiet = 5'h00;
      end else if (quiet_ff != 5'h1F) begin
         nxt_quiet = quiet_ff + 5'h01;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quiet_ff <= 5'h00;
      end else begin
         quiet_ff <= nxt_quiet;
      end
   end
   property p_take_gap;
      tx_take |=> !tx_take [*4];
   endproperty
   a_take_gap: assert property (p_take_gap)
      else $error("transmit cell shorter than five cycles");
   property p_take_ok;
      tx_take |-> link_ok && $past(tx_en);
   endproperty
   a_take_ok: assert property (p_take_ok)
      else $error("cell taken without enable or link");
   property p_link_off;
      !link_ok && !$past(link_ok) |->
         !tx_take && !mac_rx.rx_dv && !mac_rx.col;
   endproperty
   a_link_off: assert property (p_link_off)
      else $error("activity while link is down");
   property p_crs_end;
      quiet_ff == 5'h0C && !tx_en && !tx_line.drive &&
         !$past(tx_line.drive) |-> !mac_rx.crs;
   endproperty
   a_crs_end: assert property (p_crs_end)
      else $error("carrier held after line went quiet");
   property p_dv_end;
      quiet_ff == 5'h10 |-> !mac_rx.rx_dv;
   endproperty
   a_dv_end: assert property (p_dv_end)
      else $error("receive valid held after quiet line");
   property p_sq_fall;
      $fell(sq_reduced) |-> quiet_ff >= 5'h0A;
   endproperty
   a_sq_fall: assert property (p_sq_fall)
      else $error("reduced squelch left too early");
   property p_bit_gap;
      mac_rx.rx_bit_vld |=> !mac_rx.rx_bit_vld [*3];
   endproperty
   a_bit_gap: assert property (p_bit_gap)
      else $error("decoded bits too close");
   property p_col_tx;
      $rose(mac_rx.col) |-> $past(tx_en);
   endproperty
   a_col_tx: assert property (p_col_tx)
      else $error("collision without transmit");
   property p_crs_rise;
      $rose(mac_rx.crs) |-> (tx_en || $past(tx_en) || tx_line.drive)
         or (##[0:2] sq_reduced);
   endproperty
   a_crs_rise: assert property (p_crs_rise)
      else $error("carrier without transmit or qualified receive");
endmodule

// ==== tb/test_tbt_port.sv ====
/*
 Testbench of tbt_port: APB tasks, line stimulus, MAC model.
 Assumes tbt_map.svh on the include path.
*/
`timescale 1ns/10ps
`include "tbt_map.svh"
`define CHK(nm, x, g) begin n_checks++; if ((g) !== (x)) begin \
   n_errors++; $display("wrong value %s exp %0h got %0h", nm, x, g); end end
module test_tbt_port;
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, pat, rq, rxsh;
   tbt_pkg::tbt_rx_line_t rx_in;
   tbt_pkg::tbt_tx_line_t tx_line;
   tbt_pkg::tbt_mac_rx_t mac_rx;
   logic sq_reduced, sq_extended, tx_en, tx_data, tx_take, link_ok;
   logic pol_inverted, run, clr, col_mac, re, col_seen, crs_seen, sq_seen;
   logic cm_seen;
   logic [7:0] nbits;
   int n_errors = 0;
   int n_checks = 0;
   int n_takes;
   tbt_port #(.LP_PERIOD_CYC(200), .LINK_LOSS_CYC(2000),
      .JABBER_CYC(500)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .twisted_pair_rx_input(rx_in), .tx_line(tx_line),
      .sq_reduced(sq_reduced), .sq_extended(sq_extended), .tx_en(tx_en),
      .tx_data(tx_data), .tx_take(tx_take), .mac_rx(mac_rx),
      .link_ok(link_ok), .pol_inverted(pol_inverted));
   tbt_mac_model u_mac (.pclk(pclk), .presetn(presetn), .run(run),
      .pat(pat), .nbits(nbits), .tx_take(tx_take), .mac_rx(mac_rx),
      .tx_en(tx_en), .tx_data(tx_data), .col_mac(col_mac));
   always #10 pclk = ~pclk;
   always @(posedge pclk) begin
      if (clr) begin
         {col_seen, crs_seen, sq_seen, cm_seen} <= 4'h0;
         n_takes <= 0;
      end else begin
         col_seen <= col_seen | mac_rx.col;
         crs_seen <= crs_seen | mac_rx.crs;
         sq_seen <= sq_seen | sq_reduced;
         cm_seen <= cm_seen | col_mac;
         n_takes <= n_takes + int'(tx_take);
      end
      if (mac_rx.rx_bit_vld) rxsh <= {mac_rx.rx_bit, rxsh[31:1]};
   end
   task end_of_test;
      if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task hang;
      n_errors++;
      end_of_test();
   endtask
   task tick(input int k);
      repeat (k) @(posedge pclk);
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      if (pready !== 1'b1) hang();
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      `CHK("prdata", x, rq)
   endtask
   task clear;
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
   endtask
   task line(input logic p, input logic n, input int k);
      rx_in.pos <= p;
      rx_in.neg <= n;
      tick(k);
   endtask
   task pulse(input logic p);
      line(p, ~p, 2);
      line(1'b0, 1'b0, 22);
   endtask
   task wait_drive(input logic v, output int i);
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (tx_line.drive !== v && i < 400);
      if (tx_line.drive !== v) hang();
   endtask
   task rx_pkt(input logic [31:0] pt, input int n, input logic inv);
      for (int i = 0; i < n; i++) begin
         line(~pt[i] ^ inv, pt[i] ^ inv, 3);
         line(pt[i] ^ inv, ~pt[i] ^ inv, 2);
      end
      line(1'b0, 1'b0, 1);
   endtask
   task tx_frame(input logic [31:0] pt, input int n, input logic crs_x);
      int i, drv, ones, e1;
      e1 = 5;
      for (i = 0; i < n; i++) e1 += pt[i] ? 2 : 3;
      wait_drive(1'b1, i);
      wait_drive(1'b0, i);
      clear();
      pat <= pt;
      nbits <= 8'(n);
      run <= 1'b1;
      i = 0;
      drv = 0;
      ones = 0;
      do begin
         @(posedge pclk);
         i++;
         drv += int'(tx_line.drive === 1'b1);
         ones += int'(tx_line.drive === 1'b1 && tx_line.level === 1'b1);
      end while (i < 300 && !(drv > 0 && tx_en === 1'b0 &&
         tx_line.drive === 1'b0));
      if (i == 300) hang();
      run <= 1'b0;
      `CHK("drive cycles", 5 * n + 5, drv)
      `CHK("high cycles", e1, ones)
      `CHK("takes", n, n_takes)
      `CHK("tx crs", crs_x, crs_seen)
   endtask
   initial begin
      int i, w;
      {presetn, psel, penable, pwrite, run, clr} = 6'h00;
      {paddr, pwdata, pat, rxsh, nbits} = '0;
      rx_in = '0;
      tick(10);
      presetn <= 1'b1;
      rdc(`TBT_ADDR_MODE, 32'h0);
      rdc(`TBT_ADDR_SQCTRL, 32'h0);
      rdc(`TBT_ADDR_POLSTAT, 32'h0);
      rdc(`TBT_ADDR_STAT, 32'h0);
      apb(1'b1, 8'h40, 32'hFF);
      rdc(8'h40, 32'h0);
      `CHK("pslverr", 1'b1, re)
      clear();
      run <= 1'b1;
      tick(40);
      `CHK("takes link down", 0, n_takes)
      run <= 1'b0;
      pulse(1'b1);
      `CHK("link", 1'b1, link_ok)
      wait_drive(1'b1, i);
      wait_drive(1'b0, w);
      wait_drive(1'b1, i);
      `CHK("pulse width", 5, w)
      `CHK("pulse period", 200, w + i)
      apb(1'b1, `TBT_ADDR_SQCTRL, 32'h10);
      `CHK("ext squelch", 1'b1, sq_extended)
      rdc(`TBT_ADDR_SQCTRL, 32'h10);
      apb(1'b1, `TBT_ADDR_SQCTRL, 32'h0);
      for (int m = 0; m < 3; m++) begin
         apb(1'b1, `TBT_ADDR_MODE, 32'(m));
         pulse(1'b1);
         clear();
         rx_pkt(32'hD555, 16, 1'b0);
         `CHK("rx crs", 1'b1, crs_seen)
         `CHK("rx reduced", 1'b1, sq_seen)
         tick(3);
         `CHK("still valid", 1'b1, sq_reduced)
         tick(8);
         `CHK("crs end", 1'b0, mac_rx.crs)
         tick(6);
         `CHK("dv end", 1'b0, mac_rx.rx_dv)
         `CHK("reduced end", 1'b0, sq_reduced)
         `CHK("rx bits", 8'hD5, rxsh[31:24])
         tx_frame((m == 1) ? 32'h4B : 32'hB4, 8, m == 0);
      end
      for (int m = 0; m < 2; m++) begin
         apb(1'b1, `TBT_ADDR_MODE, 32'(m));
         pulse(1'b1);
         clear();
         pat <= 32'hFFFFFFFF;
         nbits <= 8'h28;
         run <= 1'b1;
         tick(10);
         rx_pkt(32'hD555, 16, 1'b0);
         tick(20);
         `CHK("overlap col", m == 0, col_seen)
         // Carrier from own transmit or from the overlapping receive
         `CHK("mac col", 1'b1, cm_seen)
         run <= 1'b0;
         wait_drive(1'b0, i);
      end
      apb(1'b1, `TBT_ADDR_MODE, 32'h0);
      pulse(1'b1);
      pat <= 32'hFFFFFFFF;
      nbits <= 8'hC8;
      run <= 1'b1;
      tick(600);
      `CHK("jabber col", 1'b1, mac_rx.col)
      apb(1'b0, `TBT_ADDR_STAT, 32'h0);
      `CHK("jabber stat", 1'b1, rq[`TBT_STAT_JAB])
      run <= 1'b0;
      tick(20);
      `CHK("jabber end", 1'b0, mac_rx.col)
      for (int k = 0; k < 2; k++) begin
         clear();
         line(1'b1, 1'b0, 1);
         line(1'b0, 1'b0, k ? 2 : 9);
         line(1'b0, 1'b1, 1);
         line(1'b0, 1'b0, k ? 10 : 2);
         line(1'b1, 1'b0, 1);
         line(1'b0, 1'b0, 30);
         `CHK("slow crs", 1'b0, crs_seen)
      end
      pulse(1'b1);
      repeat (7) pulse(1'b0);
      `CHK("pol pulses", 1'b1, pol_inverted)
      rdc(`TBT_ADDR_POLSTAT, 32'h40);
      apb(1'b1, `TBT_ADDR_SQCTRL, 32'h08);
      tick(1);
      `CHK("pol off", 1'b0, pol_inverted)
      repeat (7) pulse(1'b0);
      `CHK("pol off", 1'b0, pol_inverted)
      apb(1'b1, `TBT_ADDR_SQCTRL, 32'h0);
      repeat (3) begin
         rx_pkt(32'hD555, 16, 1'b1);
         line(1'b0, 1'b0, 30);
      end
      `CHK("pol packets", 1'b1, pol_inverted)
      tick(2100);
      `CHK("link loss", 1'b0, link_ok)
      end_of_test();
   end
endmodule
bind tbt_port tbt_port_props u_props (.pclk(pclk), .presetn(presetn),
   .twisted_pair_rx_input(twisted_pair_rx_input), .tx_line(tx_line),
   .sq_reduced(sq_reduced), .tx_en(tx_en), .tx_take(tx_take),
   .mac_rx(mac_rx), .link_ok(link_ok));
